// >>> rtl/atd_defines.svh
// Constants for the accumulator transfer decoder: opcodes, field slices, reset values.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef ATD_DEFINES_SVH
`define ATD_DEFINES_SVH

// ==========================================
// Opcodes, 10-bit instruction words
`define ATD_OPC_W          10
`define ATD_OPC_PS_AB      10'h275
`define ATD_OPC_PTR_A      10'h051
`define ATD_OPC_IRQ_A      10'h253
`define ATD_OPC_WAKE_A     10'h256

// ==========================================
// Field slices and widths
`define ATD_ACC_W          4
`define ATD_PS_W           8
`define ATD_PTR_W          3
`define ATD_PS_HI          7:4
`define ATD_PS_LO          3:0
`define ATD_ACC_PTR        2:0
`define ATD_ACC_TOP        3

// ==========================================
// Reset values
`define ATD_ACC_RST        4'h0
`define ATD_B_RST          4'h0
`define ATD_BIT_CLR        1'b0

`endif

// >>> rtl/atd_pkg.sv
// Types shared by the accumulator transfer decoder modules.
// Assumes atd_defines.svh is on the include path.
`include "atd_defines.svh"

package atd_pkg;

  // ==========================================
  // Decoded transfer kinds
  typedef enum logic [2:0] {
    ATD_NONE                   = 3'b000,
    ATD_PRESCALER_TO_ACC_AND_B = 3'b001,
    ATD_POINTER_TO_ACC         = 3'b010,
    ATD_IRQ_CTRL_TO_ACC        = 3'b011,
    ATD_WAKEUP_CTRL_TO_ACC     = 3'b100
  } atd_op_t;

  // ==========================================
  // Source registers, read only here
  typedef struct packed {
    logic [`ATD_PS_W-1:0]  prescaler_count;
    logic [`ATD_PTR_W-1:0] data_pointer_reg;
    logic [`ATD_ACC_W-1:0] irq_control_reg;
    logic [`ATD_ACC_W-1:0] wakeup_control_reg;
  } atd_src_t;

  // Write request into A and B
  typedef struct packed {
    logic                  acc_we;
    logic [`ATD_ACC_W-1:0] acc_data;
    logic                  b_we;
    logic [`ATD_ACC_W-1:0] b_data;
  } atd_wr_t;

endpackage

// >>> rtl/atd_opdec.sv
// Opcode decoder for the four transfer instructions.
// Assumes a valid strobe from the core's fetch stage on the same clock.
`timescale 1ns/1ps
`include "atd_defines.svh"

module atd_opdec #(
  parameter int OPC_W = `ATD_OPC_W
) (
  input  wire logic             instr_valid,
  input  wire logic [OPC_W-1:0] instr_opcode,
  output atd_pkg::atd_op_t      op
);
  import atd_pkg::*;

  if (OPC_W != `ATD_OPC_W) begin : g_chk
    $error("atd_opdec: opcode width must be 10");
  end

  // ==========================================
  // Full-word match; any other word is not ours
  always_comb begin
    op = ATD_NONE;
    if (instr_valid) begin
      unique case (instr_opcode)
        `ATD_OPC_PS_AB:  op = ATD_PRESCALER_TO_ACC_AND_B;
        `ATD_OPC_PTR_A:  op = ATD_POINTER_TO_ACC;
        `ATD_OPC_IRQ_A:  op = ATD_IRQ_CTRL_TO_ACC;
        `ATD_OPC_WAKE_A: op = ATD_WAKEUP_CTRL_TO_ACC;
        default:         op = ATD_NONE;
      endcase
    end
  end

endmodule

// >>> rtl/atd_xfer_core.sv
// Accumulator transfer unit: decodes four one-word transfers and updates A and B.
// Assumes one instruction per cycle, sources and core writes on sys_clk.
//
// What this block does
// - Opcode 275h loads B with prescaler bits 7..4, A with 3..0, one cycle.
// - Opcode 051h loads A with pointer in bits 2..0, bit 3 cleared.
// - Opcode 253h copies interrupt control register into A in one cycle.
// - Opcode 256h copies key-on wakeup control register into A in one cycle.
`timescale 1ns/1ps
`include "atd_defines.svh"

module atd_xfer_core #(
  parameter int OPC_W = `ATD_OPC_W
) (
  input  wire logic                  sys_clk,
  input  wire logic                  srst,
  input  wire logic                  instr_valid,
  input  wire logic [OPC_W-1:0]      instr_opcode,
  input  wire atd_pkg::atd_src_t     src,
  input  wire atd_pkg::atd_wr_t      core_wr,
  output logic [`ATD_ACC_W-1:0]      acc_r,
  output logic [`ATD_ACC_W-1:0]      b_r,
  output logic                       xfer_done_r,
  output atd_pkg::atd_op_t           xfer_op_r
);
  import atd_pkg::*;

  if (OPC_W != `ATD_OPC_W) begin : g_chk
    $error("atd_xfer_core: opcode width must be 10");
  end

  // ==========================================
  // Decode
  atd_op_t op;
  atd_wr_t xfer_wr;
  atd_wr_t wr_nxt;

  atd_opdec #(
    .OPC_W        (OPC_W)
  ) u_dec (
    .instr_valid  (instr_valid),
    .instr_opcode (instr_opcode),
    .op           (op)
  );

  // ==========================================
  // Transfer data path; sources are only read
  always_comb begin
    xfer_wr = '0;
    unique case (op)
      ATD_PRESCALER_TO_ACC_AND_B: begin
        xfer_wr.b_we     = 1'b1;
        xfer_wr.b_data   = src.prescaler_count[`ATD_PS_HI];
        xfer_wr.acc_we   = 1'b1;
        xfer_wr.acc_data = src.prescaler_count[`ATD_PS_LO];
      end
      ATD_POINTER_TO_ACC: begin
        xfer_wr.acc_we                      = 1'b1;
        xfer_wr.acc_data[`ATD_ACC_PTR]      = src.data_pointer_reg;
        xfer_wr.acc_data[`ATD_ACC_TOP]      = `ATD_BIT_CLR;
      end
      ATD_IRQ_CTRL_TO_ACC: begin
        xfer_wr.acc_we   = 1'b1;
        xfer_wr.acc_data = src.irq_control_reg;
      end
      ATD_WAKEUP_CTRL_TO_ACC: begin
        xfer_wr.acc_we   = 1'b1;
        xfer_wr.acc_data = src.wakeup_control_reg;
      end
      ATD_NONE: begin
        xfer_wr = '0;
      end
    endcase
  end

  // Decoded transfer outranks a core write to the registers it writes; a core write to the other register still lands
  always_comb begin
    wr_nxt = core_wr;
    if (xfer_wr.acc_we) begin
      wr_nxt.acc_we   = 1'b1;
      wr_nxt.acc_data = xfer_wr.acc_data;
    end
    if (xfer_wr.b_we) begin
      wr_nxt.b_we   = 1'b1;
      wr_nxt.b_data = xfer_wr.b_data;
    end
  end

  // ==========================================
  // Accumulator
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      acc_r <= `ATD_ACC_RST;
    end else if (wr_nxt.acc_we) begin
      acc_r <= wr_nxt.acc_data;
    end
  end

  // Register B, written by the prescaler read only among transfers
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      b_r <= `ATD_B_RST;
    end else if (wr_nxt.b_we) begin
      b_r <= wr_nxt.b_data;
    end
  end

  // Completion flag, one cycle after issue; carry and skip never touched
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      xfer_done_r <= 1'b0;
      xfer_op_r   <= ATD_NONE;
    end else begin
      xfer_done_r <= (op != ATD_NONE);
      xfer_op_r   <= op;
    end
  end

  // ==========================================
  // Assertions
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);

  sequence s_issue(logic [OPC_W-1:0] code);
    instr_valid && instr_opcode == code && !$past(srst);
  endsequence

  sequence s_done(atd_op_t k);
    xfer_done_r && xfer_op_r == k;
  endsequence

  AST_PS_SPLIT: assert property (
    s_issue(`ATD_OPC_PS_AB) |=> s_done(ATD_PRESCALER_TO_ACC_AND_B)
      ##0 (b_r == $past(src.prescaler_count[`ATD_PS_HI]))
      ##0 (acc_r == $past(src.prescaler_count[`ATD_PS_LO])))
    else $error("prescaler transfer wrong");

  AST_PTR_LOAD: assert property (
    s_issue(`ATD_OPC_PTR_A) |=> s_done(ATD_POINTER_TO_ACC)
      ##0 (acc_r[`ATD_ACC_PTR] == $past(src.data_pointer_reg)))
    else $error("pointer transfer wrong");

  AST_PTR_TOP_CLR: assert property (
    xfer_done_r && xfer_op_r == ATD_POINTER_TO_ACC |-> acc_r[`ATD_ACC_TOP] == 1'b0)
    else $error("accumulator bit 3 not cleared");

  AST_IRQ_LOAD: assert property (
    s_issue(`ATD_OPC_IRQ_A) |=> s_done(ATD_IRQ_CTRL_TO_ACC)
      ##0 (acc_r == $past(src.irq_control_reg)))
    else $error("interrupt control transfer wrong");

  AST_WAKE_LOAD: assert property (
    s_issue(`ATD_OPC_WAKE_A) |=> s_done(ATD_WAKEUP_CTRL_TO_ACC)
      ##0 (acc_r == $past(src.wakeup_control_reg)))
    else $error("wakeup control transfer wrong");

  // A core write to B beside a non-prescaler transfer is still taken
  AST_B_HELD: assert property (
    op != ATD_NONE && op != ATD_PRESCALER_TO_ACC_AND_B
      |=> b_r == ($past(core_wr.b_we) ? $past(core_wr.b_data) : $past(b_r)))
    else $error("register B changed by a non-prescaler transfer");

  AST_IDLE_HOLD: assert property (
    op == ATD_NONE && !core_wr.acc_we && !core_wr.b_we ##1 !$past(srst)
      |-> $stable(acc_r) && $stable(b_r))
    else $error("A or B changed without a write");

  AST_DONE_ONE: assert property (
    op == ATD_NONE |=> !xfer_done_r)
    else $error("done without a decoded transfer");

  AST_BACK2BACK: assert property (
    s_issue(`ATD_OPC_IRQ_A) ##1 s_issue(`ATD_OPC_WAKE_A)
      |=> s_done(ATD_WAKEUP_CTRL_TO_ACC) ##0 $past(xfer_done_r))
    else $error("back-to-back transfers not both one cycle");

  // ==========================================
  // Refusals and core writes
  // Words outside the four must leave no trace, even one bit away
  sequence s_foreign;
    instr_valid && !(instr_opcode inside {`ATD_OPC_PS_AB, `ATD_OPC_PTR_A,
                                          `ATD_OPC_IRQ_A, `ATD_OPC_WAKE_A});
  endsequence

  sequence s_quiet;
    !xfer_done_r && xfer_op_r == ATD_NONE;
  endsequence

  // Nothing is reported in the cycle after a refused word
  AST_NO_STROBE: assert property (
    !instr_valid |=> s_quiet)
    else $error("transfer reported without a valid strobe");

  AST_FOREIGN_WORD: assert property (
    s_foreign |=> s_quiet)
    else $error("transfer reported for an unknown word");

  // The core keeps its own path into A and B when no transfer claims them
  AST_ACC_CORE_WR: assert property (
    op == ATD_NONE && core_wr.acc_we |=> acc_r == $past(core_wr.acc_data))
    else $error("core write to A lost");

  AST_B_CORE_WR: assert property (
    op != ATD_PRESCALER_TO_ACC_AND_B && core_wr.b_we |=> b_r == $past(core_wr.b_data))
    else $error("core write to B lost");

  // Conflicts: the transfer wins only the registers it writes
  AST_PS_WINS: assert property (
    s_issue(`ATD_OPC_PS_AB) ##0 core_wr.acc_we ##0 core_wr.b_we
      |=> acc_r == $past(src.prescaler_count[`ATD_PS_LO])
      ##0 b_r == $past(src.prescaler_count[`ATD_PS_HI]))
    else $error("core write beat the prescaler transfer");

  AST_PTR_WINS: assert property (
    s_issue(`ATD_OPC_PTR_A) ##0 core_wr.acc_we
      |=> acc_r == {`ATD_BIT_CLR, $past(src.data_pointer_reg)})
    else $error("core write beat the pointer transfer");

  AST_IRQ_WINS: assert property (
    s_issue(`ATD_OPC_IRQ_A) ##0 core_wr.acc_we
      |=> acc_r == $past(src.irq_control_reg))
    else $error("core write beat the interrupt control transfer");

  AST_WAKE_B_FREE: assert property (
    s_issue(`ATD_OPC_WAKE_A) ##0 core_wr.b_we
      |=> b_r == $past(core_wr.b_data))
    else $error("core write to B lost beside a wakeup transfer");

endmodule

// >>> tb/tb_top.sv
// Self-checking bench for the accumulator transfer unit: random and corner instruction traffic.
// Assumes atd_pkg is compiled first and rtl/ is on the include path.
`timescale 1ns/1ps
`include "atd_defines.svh"

module tb_top;
  import atd_pkg::*;

  // ==========================================
  // Stimulus and observed signals
  logic       sys_clk      = 1'b0;
  logic       srst         = 1'b1;
  logic       instr_valid  = 1'b0;
  logic [9:0] instr_opcode = 10'h000;
  atd_src_t   src          = '0;
  atd_wr_t    core_wr      = '0;
  logic [3:0] acc_r;
  logic [3:0] b_r;
  logic       xfer_done_r;
  atd_op_t    xfer_op_r;
  int         n_mismatch   = 0;
  int         compares     = 0;
  int         seed         = 4078;
  logic [3:0] exp_acc      = 4'h0;
  logic [3:0] exp_b        = 4'h0;
  // Four legal opcodes, then near misses one bit away
  logic [9:0] opc_tab [7]  = '{`ATD_OPC_PS_AB, `ATD_OPC_PTR_A, `ATD_OPC_IRQ_A,
                               `ATD_OPC_WAKE_A, 10'h274, 10'h050, 10'h257};

  always #12.5 sys_clk = ~sys_clk;

  atd_xfer_core atd_xfer_core_i (
    .sys_clk      (sys_clk),
    .srst         (srst),
    .instr_valid  (instr_valid),
    .instr_opcode (instr_opcode),
    .src          (src),
    .core_wr      (core_wr),
    .acc_r        (acc_r),
    .b_r          (b_r),
    .xfer_done_r  (xfer_done_r),
    .xfer_op_r    (xfer_op_r)
  );

  // ==========================================
  // Expectation and comparison helpers
  function automatic atd_op_t kind_of(logic v, logic [9:0] opc);
    if (!v) return ATD_NONE;
    case (opc)
      `ATD_OPC_PS_AB:  return ATD_PRESCALER_TO_ACC_AND_B;
      `ATD_OPC_PTR_A:  return ATD_POINTER_TO_ACC;
      `ATD_OPC_IRQ_A:  return ATD_IRQ_CTRL_TO_ACC;
      `ATD_OPC_WAKE_A: return ATD_WAKEUP_CTRL_TO_ACC;
      default:         return ATD_NONE;
    endcase
  endfunction

  task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wrap_up;
    $display("Comparisons %0d, mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // One cycle: drive just after an edge, model the next edge, compare once it has landed
  task automatic step(logic rst, logic v, logic [9:0] opc, atd_src_t s, atd_wr_t w);
    atd_op_t k;
    k = rst ? ATD_NONE : kind_of(v, opc);
    srst         = rst;
    instr_valid  = v;
    instr_opcode = opc;
    src          = s;
    core_wr      = w;
    @(posedge sys_clk);
    if (rst) begin
      exp_acc = 4'h0;
      exp_b   = 4'h0;
    end else begin
      // Transfer wins over a core write to the same register
      if (k == ATD_PRESCALER_TO_ACC_AND_B) begin
        exp_acc = s.prescaler_count[3:0];
        exp_b   = s.prescaler_count[7:4];
      end else if (k == ATD_POINTER_TO_ACC) exp_acc = {1'b0, s.data_pointer_reg};
      else if (k == ATD_IRQ_CTRL_TO_ACC) exp_acc = s.irq_control_reg;
      else if (k == ATD_WAKEUP_CTRL_TO_ACC) exp_acc = s.wakeup_control_reg;
      else if (w.acc_we) exp_acc = w.acc_data;
      if (k != ATD_PRESCALER_TO_ACC_AND_B && w.b_we) exp_b = w.b_data;
    end
    #1;
    check("acc_r", {4'h0, acc_r}, {4'h0, exp_acc});
    check("b_r", {4'h0, b_r}, {4'h0, exp_b});
    check("xfer_done_r", {7'h00, xfer_done_r}, {7'h00, k != ATD_NONE});
    check("xfer_op_r", {5'h00, xfer_op_r}, {5'h00, k});
  endtask

  // ==========================================
  // Main sequence
  initial begin
    int       idx;
    logic [9:0] opc;
    repeat (4) step(1'b1, 1'b0, 10'h000, '0, '0);
    // Prescaler split with distinct nibbles
    step(1'b0, 1'b1, `ATD_OPC_PS_AB, {8'hA5, 3'h2, 4'h6, 4'h9}, '0);
    // All four back to back, each against conflicting core writes; pointer top bit forced low
    for (int i = 0; i < 4; i++)
      step(1'b0, 1'b1, opc_tab[i], {8'h3C, 3'h7, 4'hE, 4'hB}, {1'b1, 4'hF, 1'b1, 4'hF});
    // Legal opcode without strobe, then near misses
    step(1'b0, 1'b0, `ATD_OPC_PS_AB, {8'hFF, 3'h5, 4'h1, 4'h2}, '0);
    for (int i = 4; i < 7; i++) step(1'b0, 1'b1, opc_tab[i], {8'h77, 3'h1, 4'h3, 4'h4}, '0);
    // Random traffic with a reset in mid-run
    for (int i = 0; i < 3000; i++) begin
      idx = ($random(seed) & 32'h0000_0007);
      opc = (idx == 7) ? 10'($random(seed)) : opc_tab[idx];
      step(i >= 1500 && i < 1502, 1'($random(seed)), opc,
           atd_src_t'(19'($random(seed))), atd_wr_t'(10'($random(seed))));
    end
    wrap_up;
  end
endmodule
